// [hw/sarseq_pkg.sv]
// Package with register map, field positions, reset values and timing for the sequencer
package sarseq_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL_ONE = 8'h00;   // converter_control_one
    localparam logic [7:0] OFF_CTRL_TWO = 8'h04;   // converter_control_two
    localparam logic [7:0] OFF_CTRL_THREE = 8'h08; // converter_control_three
    localparam logic [7:0] OFF_INSEL = 8'h0c;      // input_select_reg
    localparam logic [7:0] OFF_PCFG = 8'h10;       // port_config_reg
    localparam logic [7:0] OFF_SCAN = 8'h14;       // scan_select_reg
    localparam logic [7:0] OFF_STATUS = 8'h18;     // sequencer state and converter_irq_flag, flag write 1 to clear
    localparam logic [7:0] OFF_BUF = 8'h40;        // result_store, 16 words
    // ****************************************************************
    // Field positions, control one
    // ****************************************************************
    localparam int CONE_ON = 15;       // converter_on
    localparam int CONE_SSRC = 5;      // trigger_source_sel, 3 bits
    localparam int CONE_SIMULTANEOUS_SAMPLE_BIT = 3;    // simultaneous_sample_bit
    localparam int CONE_AUTO_SAMPLE_BIT = 2;      // auto_sample_bit
    localparam int CONE_SAMPLE_START_BIT = 1;      // sample_start_bit
    localparam int CONE_DONE = 0;      // done bit, read only
    // ****************************************************************
    // Field positions, control two
    // ****************************************************************
    localparam int CTWO_SCAN_ENABLE_BIT = 10;    // scan_enable_bit
    localparam int CTWO_CHANNEL_COUNT_SEL = 8;      // channel_count_sel, 2 bits
    localparam int CTWO_BUFS = 7;      // half being written, read only
    localparam int CTWO_SMPI = 2;      // sequences_per_irq, 4 bits
    localparam int CTWO_BUFFER_SPLIT_BIT = 1;      // buffer_split_bit
    localparam int CTWO_ALTERNATE_INPUT_BIT = 0;      // alternate_input_bit
    // ****************************************************************
    // Field positions, control three and status
    // ****************************************************************
    localparam int CTHR_AUTO_SAMPLE_CLOCKS = 8;      // auto_sample_clocks, 5 bits
    localparam int CTHR_ADCS = 0;      // conv_clock_divider, 6 bits
    localparam int STAT_IRQF = 0;      // converter_irq_flag, write 1 to clear
    // ****************************************************************
    // Codes, reset values and timing
    // ****************************************************************
    localparam logic [2:0] SSRC_SOFT = 3'h0;  // Clearing sample bit converts
    localparam logic [2:0] SSRC_TIMER = 3'h2; // Timer time-out pin
    localparam logic [2:0] SSRC_EXT = 3'h1;   // External event pin
    localparam logic [2:0] SSRC_AUTO = 3'h7;  // Count of clocks after start
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam logic [4:0] CONV_TAD = 5'h0c;  // 12 periods per conversion
    localparam logic [1:0] ABORT_TAD = 2'h2;  // Wait after abort
    localparam real CLK_NS = 8.0;             // 125 MHz
endpackage

// [hw/sarseq_tad_div.sv]
// Conversion clock divider producing a one-cycle period enable
`timescale 1ns/1ns
`default_nettype none
module sarseq_tad_div (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic run,
    input wire logic [5:0] divider,
    // Period enable
    output logic tad_tick
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [6:0] cnt; // Half-period count
        logic tick;      // Registered tick
    } sarseq_div_s;
    sarseq_div_s r;
    sarseq_div_s next_r;

    // Period is (divider + 1) half instruction cycles, here whole clocks
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (!run) begin
            next_r.cnt = 7'h00;
        end else if (r.cnt >= {1'b0, divider}) begin
            next_r.cnt = 7'h00;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 7'h01;
        end
    end

    // Register the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tad_tick = r.tick;
endmodule
`default_nettype wire

// [hw/sarseq_top.sv]
// Sequencer for the 10-bit successive-approximation converter with AXI4-Lite registers
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ns
`default_nettype none
module sarseq_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Trigger pins, asynchronous
    input wire logic timer_trig,
    input wire logic ext_trig,
    // Analog front end
    output logic [3:0] sh_sample,      // Hold amplifiers tracking
    output logic [1:0] conv_channel,   // Hold being converted
    output logic conv_start,           // One-cycle start of a conversion
    output logic [3:0] ch0_input,      // Input routed to first hold
    output logic ch_alt_set,           // Secondary input set in use
    output logic [15:0] analog_pin_en, // Pins that are analog
    input wire logic [9:0] conv_result // Converter result at end
);
    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, // Off or waiting for sample bit
        ST_SAMPLE_START_BIT = 4'b0010, // Acquiring
        ST_CONV = 4'b0100, // Converting one hold
        ST_WAIT = 4'b1000  // Post-abort hold-off
    } sarseq_st_e;

    // ****************************************************************
    // Module state apart from the result store, ch0_q and the divider
    // ****************************************************************
    typedef struct packed {
        sarseq_st_e st;
        logic [31:0] c1, c2, c3, insel, pcfg, scan;
        logic irqf, done, half, alt;     // Flag, done, store half, set B
        logic [3:0] wptr, seq, scan_pos; // Store pointer, sequence count, scan
        logic [1:0] ch;                  // Hold in progress
        logic [4:0] tcnt;                // Period counter
        logic sample_start_bit_q;                    // Previous sample bit
        logic [1:0] tsync, esync, tq;    // Pin synchronisers, edge history
        logic aw, w; logic [7:0] awa; logic [31:0] wd; logic [3:0] ws;
        logic bv, rv; logic [31:0] rd;
        logic [3:0] sh; logic cs;
    } sarseq_s;
    sarseq_s r;
    sarseq_s next_r;
    logic [9:0] store [16];            // Result store
    logic wr_en;                       // Store write this cycle
    logic tad;                         // Conversion period enable
    logic on;                          // converter_on
    logic [1:0] nch;                   // Holds minus one

    assign on = r.c1[sarseq_pkg::CONE_ON];
    assign nch = (r.c2[sarseq_pkg::CTWO_CHANNEL_COUNT_SEL+1]) ? 2'h3 :
                 (r.c2[sarseq_pkg::CTWO_CHANNEL_COUNT_SEL] ? 2'h1 : 2'h0);

    sarseq_tad_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(on),
        .divider(r.c3[sarseq_pkg::CTHR_ADCS +: 6]),
        .tad_tick(tad)
    );

    // Next input on scan list at or after a position
    function automatic logic [3:0] scan_next(input logic [15:0] sel, input logic [3:0] from);
        logic [3:0] res;
        logic hit;
        res = from;
        hit = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (!hit && i >= int'(from) && sel[i]) begin
                res = 4'(i);
                hit = 1'b1;
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic trig, last_seq, ar_ok;
        logic irq_set;
        next_r = r;
        wr_en = 1'b0;
        trig = 1'b0;
        last_seq = 1'b0;
        ar_ok = 1'b0;
        irq_set = 1'b0;
        next_r.cs = 1'b0;
        // Pin synchronisers; only the second stage is looked at
        next_r.tsync = {r.tsync[0], timer_trig};
        next_r.esync = {r.esync[0], ext_trig};
        next_r.tq = {r.tsync[1], r.esync[1]};
        next_r.sample_start_bit_q = r.c1[sarseq_pkg::CONE_SAMPLE_START_BIT];
        unique case (r.c1[sarseq_pkg::CONE_SSRC +: 3])
            sarseq_pkg::SSRC_SOFT: trig = r.sample_start_bit_q & ~r.c1[sarseq_pkg::CONE_SAMPLE_START_BIT];
            sarseq_pkg::SSRC_TIMER: trig = r.tsync[1] & ~r.tq[1];
            sarseq_pkg::SSRC_EXT: trig = r.esync[1] & ~r.tq[0];
            // clock count after start, at least one
            sarseq_pkg::SSRC_AUTO: trig = tad && (r.tcnt + 5'h01 >=
                r.c3[sarseq_pkg::CTHR_AUTO_SAMPLE_CLOCKS +: 5]);
            default: trig = 1'b0;
        endcase
        // no sleep input: sequencing never pauses
        unique case (r.st)
            ST_IDLE: begin
                if (on && r.c1[sarseq_pkg::CONE_SAMPLE_START_BIT]) begin
                    next_r.st = ST_SAMPLE_START_BIT;
                    next_r.tcnt = 5'h00;
                    next_r.done = 1'b0;
                end
            end
            ST_SAMPLE_START_BIT: begin
                if (tad) begin
                    next_r.tcnt = r.tcnt + 5'h01;
                end
                if (trig) begin
                    next_r.st = ST_CONV;
                    next_r.tcnt = 5'h00;
                    next_r.cs = 1'b1;
                    if (r.c3[sarseq_pkg::CTHR_AUTO_SAMPLE_CLOCKS +: 5] == 5'h00 &&
                        r.c1[sarseq_pkg::CONE_SSRC +: 3] == sarseq_pkg::SSRC_AUTO) begin
                        next_r.st = ST_SAMPLE_START_BIT;
                        next_r.cs = 1'b0;
                    end
                    if (r.c1[sarseq_pkg::CONE_SSRC +: 3] != sarseq_pkg::SSRC_SOFT) begin
                        next_r.c1[sarseq_pkg::CONE_SAMPLE_START_BIT] = 1'b0;
                    end
                end
            end
            ST_CONV: begin
                if (tad) begin
                    next_r.tcnt = r.tcnt + 5'h01;
                end
                if (tad && r.tcnt + 5'h01 == sarseq_pkg::CONV_TAD) begin
                    wr_en = 1'b1;
                    next_r.wptr = r.wptr + 4'h1;
                    next_r.tcnt = 5'h00;
                    if (r.ch != nch) begin
                        next_r.ch = r.ch + 2'h1;
                        next_r.cs = r.c1[sarseq_pkg::CONE_SIMULTANEOUS_SAMPLE_BIT]; // Sequential: sample first
                        next_r.st = r.c1[sarseq_pkg::CONE_SIMULTANEOUS_SAMPLE_BIT] ? ST_CONV : ST_SAMPLE_START_BIT;
                    end else begin
                        next_r.ch = 2'h0;
                        last_seq = (r.seq == r.c2[sarseq_pkg::CTWO_SMPI +: 4]);
                        next_r.alt = r.c2[sarseq_pkg::CTWO_ALTERNATE_INPUT_BIT] & ~r.alt;
                        // scan advances past the input used
                        next_r.scan_pos = scan_next(r.scan[15:0], r.scan_pos) + 4'h1;
                        next_r.seq = r.seq + 4'h1;
                        // group of count field plus one
                        if (last_seq) begin
                            next_r.irqf = 1'b1;
                            next_r.done = 1'b1;
                            next_r.seq = 4'h0;
                            next_r.half = r.c2[sarseq_pkg::CTWO_BUFFER_SPLIT_BIT] & ~r.half;
                            next_r.wptr = 4'h0;
                            next_r.scan_pos = 4'h0;
                        end
                        next_r.st = (r.c1[sarseq_pkg::CONE_AUTO_SAMPLE_BIT] && on) ? ST_SAMPLE_START_BIT : ST_IDLE;
                        next_r.c1[sarseq_pkg::CONE_SAMPLE_START_BIT] = r.c1[sarseq_pkg::CONE_AUTO_SAMPLE_BIT];
                    end
                end
            end
            ST_WAIT: begin
                if (tad) begin
                    next_r.tcnt = r.tcnt + 5'h01;
                end
                if (r.tcnt >= {3'h0, sarseq_pkg::ABORT_TAD}) begin
                    next_r.st = ST_IDLE;
                end
            end
        endcase
        next_r.sh = 4'h0;
        if (next_r.st == ST_SAMPLE_START_BIT) begin
            next_r.sh = r.c1[sarseq_pkg::CONE_SIMULTANEOUS_SAMPLE_BIT] ? {nch[1], nch[1], nch[0], 1'b1}
                                                      : 4'(1 << next_r.ch);
        end
        if (!on && r.st != ST_IDLE && r.st != ST_WAIT) begin
            next_r.st = ST_WAIT;
            next_r.tcnt = 5'h00;
            next_r.ch = 2'h0;
            next_r.sh = 4'h0;
            next_r.cs = 1'b0;
            wr_en = 1'b0;
            // Sequencing restarts; a coinciding group end is dropped
            next_r.irqf = r.irqf;
            next_r.done = r.done;
            next_r.half = r.half;
            next_r.seq = 4'h0;
            next_r.wptr = 4'h0;
            next_r.scan_pos = 4'h0;
            next_r.alt = 1'b0;
        end
        // Group end that survived an abort; it beats a flag clear
        irq_set = last_seq && wr_en;
        // AXI write: capture address and data in any order
        if (s_axi_awvalid && !r.aw) begin
            next_r.aw = 1'b1;
            next_r.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w) begin
            next_r.w = 1'b1;
            next_r.wd = s_axi_wdata;
            next_r.ws = s_axi_wstrb;
        end
        if (r.aw && r.w && !r.bv) begin
            next_r.aw = 1'b0;
            next_r.w = 1'b0;
            next_r.bv = 1'b1;
            // settings writes are accepted; software keeps them still while on
            unique case (r.awa & 8'hfc)
                sarseq_pkg::OFF_CTRL_ONE: next_r.c1 = r.wd & 32'h0000_80ee;
                sarseq_pkg::OFF_CTRL_TWO: next_r.c2 = r.wd & 32'h0000_077f;
                sarseq_pkg::OFF_CTRL_THREE: next_r.c3 = r.wd & 32'h0000_1f3f;
                sarseq_pkg::OFF_INSEL: next_r.insel = r.wd & 32'h0000_1f1f;
                sarseq_pkg::OFF_PCFG: next_r.pcfg = r.wd & 32'h0000_ffff;
                sarseq_pkg::OFF_SCAN: next_r.scan = r.wd & 32'h0000_ffff;
                sarseq_pkg::OFF_STATUS: begin
                    if (r.wd[sarseq_pkg::STAT_IRQF] && !irq_set) begin
                        next_r.irqf = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (r.bv && s_axi_bready) begin
            next_r.bv = 1'b0;
        end
        // AXI read
        if (s_axi_arvalid && !r.rv) begin
            next_r.rv = 1'b1;
            ar_ok = 1'b1;
            unique case (s_axi_araddr & 8'hfc)
                sarseq_pkg::OFF_CTRL_ONE: next_r.rd = {r.c1[31:1], r.done};
                sarseq_pkg::OFF_CTRL_TWO: next_r.rd = {r.c2[31:8], r.half, r.c2[6:0]};
                sarseq_pkg::OFF_CTRL_THREE: next_r.rd = r.c3;
                sarseq_pkg::OFF_INSEL: next_r.rd = r.insel;
                sarseq_pkg::OFF_PCFG: next_r.rd = r.pcfg;
                sarseq_pkg::OFF_SCAN: next_r.rd = r.scan;
                sarseq_pkg::OFF_STATUS: next_r.rd = {24'h0, r.st, 3'h0, r.irqf};
                default: begin
                    next_r.rd = 32'h0000_0000;
                    ar_ok = 1'b0;
                end
            endcase
            if ((s_axi_araddr & 8'hc0) == sarseq_pkg::OFF_BUF) begin
                next_r.rd = {22'h0, store[s_axi_araddr[5:2]]};
                ar_ok = 1'b1;
            end
            if (!ar_ok) begin
                next_r.rd = 32'h0000_0000;
            end
        end
        if (r.rv && s_axi_rready) begin
            next_r.rv = 1'b0;
        end
    end

    // ****************************************************************
    // Registers and result store
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Store has no reset; contents persist across aborts
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            store[{r.half & r.c2[sarseq_pkg::CTWO_BUFFER_SPLIT_BIT], 3'h0} + r.wptr] <= conv_result;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic [3:0] ch0_q;
    // first hold input: scan, secondary or primary set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch0_q <= 4'h0;
        end else if (r.c2[sarseq_pkg::CTWO_SCAN_ENABLE_BIT] && !r.alt) begin
            ch0_q <= scan_next(r.scan[15:0], r.scan_pos);
        end else begin
            ch0_q <= r.alt ? r.insel[11:8] : r.insel[3:0];
        end
    end

    assign s_axi_awready = ~r.aw;
    assign s_axi_wready = ~r.w;
    assign s_axi_bresp = 2'h0;
    assign s_axi_bvalid = r.bv;
    assign s_axi_arready = ~r.rv;
    assign s_axi_rdata = r.rd;
    assign s_axi_rresp = 2'h0;
    assign s_axi_rvalid = r.rv;
    assign sh_sample = r.sh;
    assign conv_channel = r.ch;
    assign conv_start = r.cs;
    assign ch0_input = ch0_q;
    assign ch_alt_set = r.alt;
    assign analog_pin_en = ~r.pcfg[15:0];
endmodule
`default_nettype wire

// [tb/sarseq_afe_model.sv]
// Behavioural analog front end answering each conversion
`timescale 1ns/1ns
`default_nettype none
module sarseq_afe_model (
    // Clock and converter handshake
    input wire logic aclk,
    input wire logic conv_start,
    input wire logic [1:0] conv_channel,
    input wire logic [3:0] ch0_input,
    output logic [9:0] conv_result
);
    logic [3:0] left = 4'h0; // Cycles left in the conversion
    logic [3:0] held = 4'h0; // Input captured at the start
    logic [9:0] pat; // Level seen by the converter
    assign pat = {2'h2, held, 2'h1, conv_channel};
    // Capture the held input; window a little longer than twelve periods
    always @(posedge aclk) begin
        if (conv_start) begin
            left <= 4'hd;
            held <= ch0_input;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    // Outside a conversion no stale value is left on the line
    assign conv_result = (left != 4'h0) ? pat : ~pat;
endmodule
`default_nettype wire

// [tb/sarseq_sva.sv]
// Checker of port relations for the sequencer
`timescale 1ns/1ns
`default_nettype none
module sarseq_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Converter start pulse
    input wire logic conv_start
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0) else $error("bresp not okay");
    a_rokay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0) else $error("rresp not okay");
    a_bhold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_rhold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    a_wans: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
    a_conv: assert property (conv_start |=> !conv_start [*8]) else $error("conversion too short");
    a_store: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:6] == 2'h1
        |=> s_axi_rdata[31:10] == 22'h0) else $error("store word too wide");
endmodule
bind sarseq_top sarseq_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .conv_start(conv_start));
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic aclk = 1'b0; // Bus clock
    logic aresetn = 1'b0; // Held low at start
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, conv_start, alt_set;
    logic [1:0] bresp, rresp, chan;
    logic [3:0] sh_sample, ch0_input;
    logic [15:0] pin_en;
    logic [9:0] conv_result;
    int num_errors = 0;
    int n_compared = 0;
    always #4 aclk = ~aclk;
    sarseq_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer_trig(1'b0), .ext_trig(1'b0), .sh_sample(sh_sample), .conv_channel(chan),
        .conv_start(conv_start), .ch0_input(ch0_input), .ch_alt_set(alt_set),
        .analog_pin_en(pin_en), .conv_result(conv_result));
    sarseq_afe_model afe (.aclk(aclk), .conv_start(conv_start), .conv_channel(chan),
        .ch0_input(ch0_input), .conv_result(conv_result));
    // Count a comparison and report a difference
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Word the front end gives for an input on the first hold
    function automatic logic [31:0] res(input logic [3:0] n);
        return {22'h0, 2'h2, n, 2'h1, 2'h0};
    endfunction
    // One write; each channel is released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Readies are looked at mid-cycle, where they have settled
        do begin
            @(negedge aclk);
            pa = pa && !awready;
            pw = pw && !wready;
            @(posedge aclk);
            awvalid <= pa;
            wvalid <= pw;
        end while (pa || pw);
        do @(negedge aclk); while (!bvalid);
        chk("bresp", 32'(bresp), 32'h0);
        @(posedge aclk);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    // One read; data taken at the edge where rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        d = rdata;
        @(posedge aclk);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Poll the flag under a bound, then clear it by writing one
    task automatic wait_irq();
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 300 && !s[0]; i++) rd(8'h18, s);
        chk("irq flag", 32'(s[0]), 32'h1);
        wr(8'h18, 32'h1);
    endtask
    // Reset value, unmapped write, pin mask
    task automatic t_regs();
        logic [31:0] d;
        rd(8'h04, d);
        chk("ctrl_two reset", d, 32'h0);
        wr(8'h30, 32'hffff_ffff);
        rd(8'h30, d);
        chk("unmapped read", d, 32'h0);
        wr(8'h10, 32'h0000_ff00);
        chk("analog_pin_en", 32'(pin_en), 32'h0000_00ff);
    endtask
    // Scan of inputs 1 and 4, two sequences per flag, auto trigger
    task automatic t_scan();
        logic [31:0] d;
        wr(8'h14, 32'h0000_0012);
        wr(8'h08, 32'h0000_0100);
        wr(8'h04, 32'h0000_0404);
        wr(8'h00, 32'h0000_80e6);
        wait_irq();
        rd(8'h40, d);
        chk("scan first", d, res(4'h1));
        rd(8'h44, d);
        chk("scan second", d, res(4'h4));
        wr(8'h40, 32'h0000_ffff);
        rd(8'h40, d);
        chk("store read only", d, res(4'h1));
    endtask
    // Split store with alternating input sets, one sequence per flag
    task automatic t_split_alt();
        logic [31:0] d;
        wr(8'h00, 32'h0);
        wr(8'h18, 32'h1);
        rd(8'h40, d);
        chk("store kept", d, res(4'h1));
        wr(8'h0c, 32'h0000_0502);
        wr(8'h04, 32'h0000_0003);
        wr(8'h00, 32'h0000_80e6);
        wait_irq();
        wait_irq();
        rd(8'h40, d);
        chk("half zero", d, res(4'h2));
        rd(8'h60, d);
        chk("half one", d, res(4'h5));
        wr(8'h00, 32'h0);
    endtask
    // Print the counts and the verdict, then stop
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence after two cycles of reset
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_scan();
        t_split_alt();
        final_report();
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
